// ===== card_clk_div.sv
`timescale 1ns/1ps

// ****************************************
// Fractional card clock divider
// ****************************************
module card_clk_div
  import sdh_pkg::*;
#(
  // The widest divisor product needs 21 bits, so the default keeps one spare.
  parameter int ACC_W = 22
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic [N_W-1:0]   n_i,
  input  wire logic [M_W-1:0]   m_i,
  output logic                  card_bus_clock_o
);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] period;
  logic [ACC_W-1:0] sixteenths;
  logic [ACC_W-1:0] mult;
  logic             tick;
  logic             clk_r;

  // Full period in base-clock sixteenths is 2 * divisor * (16N + M), or 16N + M when the divisor is 0;
  // each base cycle adds 32 so the clock toggles twice per period.
  assign sixteenths = ACC_W'({n_i, 4'h0}) + ACC_W'(m_i);
  assign mult       = (div_i == '0) ? ACC_W'(1) : ACC_W'({div_i, 1'b0});
  assign period     = ACC_W'(sixteenths * mult);
  assign tick       = (acc_r + ACC_W'(32)) >= period;
  assign acc_nxt    = tick ? ACC_W'(acc_r + ACC_W'(32) - period)
                           : ACC_W'(acc_r + ACC_W'(32));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_r <= '0;
      clk_r <= 1'b0;
    end
    else if (!run_i)
    begin
      acc_r <= '0;
      clk_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      if (tick)
        clk_r <= ~clk_r;
    end
  end

  assign card_bus_clock_o = clk_r;

endmodule : card_clk_div

// ===== host_bus_model.sv
`timescale 1ns/1ps
// ****************
// Host processor on the memory bus
// ****************
module host_bus_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] data_o,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o
);
  initial
  begin
    cs_n_o  = 1'b1;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    addr_o  = 8'h00;
    wdata_o = 16'h0000;
  end
  // One whole 16-bit word per access; the released data bus shows the inverse so stale data cannot pass.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cs_n_o  <= 1'b0;
    wr_n_o  <= 1'b0;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    cs_n_o  <= 1'b1;
    wr_n_o  <= 1'b1;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    d = data_o;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
  endtask : rd
endmodule : host_bus_model

// ===== sdh_pkg.sv
package sdh_pkg;

  // ****************************************
  // Register word offsets (byte address)
  // ****************************************
  localparam logic [7:0] OFS_PWR_CTRL  = 8'h28;
  localparam logic [7:0] OFS_CLK_CTRL  = 8'h2c;
  localparam logic [7:0] OFS_SW_RESET  = 8'h2e;
  localparam logic [7:0] OFS_CLK_FRAC  = 8'hf6;
  localparam logic [7:0] OFS_MISC      = 8'hf8;
  localparam logic [7:0] OFS_PLL_CTRL  = 8'hfa;
  localparam logic [7:0] OFS_REVISION  = 8'hfe;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PWR_BUS_ON_BIT   = 8;
  localparam int CLK_INT_EN_BIT   = 0;
  localparam int CLK_IDLE_BIT     = 2;
  localparam int CLK_DIV_LSB      = 8;
  localparam int SWRST_ALL_BIT    = 8;
  localparam int FRAC_N_LSB       = 0;
  localparam int FRAC_M_LSB       = 8;
  localparam int MISC_COMA_BIT    = 0;
  localparam int MISC_DMA_EN_BIT  = 1;
  localparam int MISC_INT_PP_BIT  = 2;
  localparam int MISC_HIBERN_BIT  = 3;
  localparam int PLL_BYPASS_BIT   = 15;
  localparam int PLL_DIRECT_BIT   = 14;
  localparam int PLL_POST_LSB     = 5;
  localparam int PLL_FB_LSB       = 0;
  localparam int REV_CODE_LSB     = 8;

  // ****************************************
  // Field widths and reset values
  // ****************************************
  localparam int FB_W   = 5;
  localparam int POST_W = 2;
  localparam int N_W    = 8;
  localparam int M_W    = 4;
  localparam int DIV_W  = 8;

  localparam logic [FB_W-1:0]   FB_RST      = 5'h04;
  localparam logic [POST_W-1:0] POST_RST    = 2'h1;
  localparam logic              BYPASS_RST  = 1'b1;
  localparam logic              DIRECT_RST  = 1'b1;
  localparam logic [N_W-1:0]    N_RST       = 8'h01;
  localparam logic [M_W-1:0]    M_RST       = 4'h0;
  localparam logic              DMA_EN_RST  = 1'b1;
  localparam logic [15:0]       PLL_RD_MASK = 16'hc07f;

  // Arbitrary neutral revision code.
  localparam logic [7:0]        REV_CODE    = 8'h21;

  // ****************************************
  // Power states
  // ****************************************
  typedef enum logic [2:0] {
    PS_RUN     = 3'b000,
    PS_IDLE    = 3'b001,
    PS_STANDBY = 3'b010,
    PS_HIBERN  = 3'b011,
    PS_COMA    = 3'b100
  } pwr_state_t;

endpackage : sdh_pkg

// ===== sdh_power_clock.sv
`timescale 1ns/1ps

// Operation
// - PLL output equals input times feedback plus one
// - Feedback divider resets to four
// - Bit 15 bypasses PLL, resets to one
// - Bit 14 bypasses post divider, resets one
// - Post divider from bits 6:5, reset one
// - Post divider never changes PLL frequency
// - Revision low byte zero, high byte code
// - Clock control bit 2 stops card clock
// - Power bit 8 switches card supply
// - Clearing internal clock enters standby
// - Leaving standby empties buffer pointers
// - Coma bit cuts power, tristates pins
// - Coma loses all internal state
// - Hibernate stops oscillator, PLL, buffer supply
// - Hibernate wake empties buffer pointers
// - Card detect disabled in hibernate, coma
// - Card interrupts blocked in hibernate, coma
// - Host reaches registers over 16-bit bus
// - Drive external card supply switch output
// - Card clock is PLL over fractional divisor
module sdh_power_clock
  import sdh_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [15:0]       data_i,
  output logic      [15:0]       data_o,
  output logic                   data_oe_o,
  input  wire logic              card_detect_input_i,
  input  wire logic              card_irq_i,
  output logic                   card_present_o,
  output logic                   card_irq_o,
  output logic                   card_bus_clock_o,
  output logic                   card_supply_en_o,
  output logic                   osc_en_o,
  output logic                   pll_power_down_o,
  output logic                   pll_bypass_o,
  output logic                   pll_direct_o,
  output logic      [FB_W-1:0]   pll_fb_div_o,
  output logic      [POST_W-1:0] pll_post_div_o,
  output logic                   buffer_power_en_o,
  output logic                   buffer_ptr_reset_o,
  output logic                   dma_req_en_o,
  output logic                   int_push_pull_o,
  output logic                   pins_active_o,
  output logic      [2:0]        power_state_o
);

  import sdh_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic              bus_on_r;
  logic              int_clk_en_r;
  logic              idle_r;
  logic [DIV_W-1:0]  div_r;
  logic [N_W-1:0]    frac_n_r;
  logic [M_W-1:0]    frac_m_r;
  logic              coma_r;
  logic              dma_en_r;
  logic              int_pp_r;
  logic              hibern_r;
  logic              bypass_r;
  logic              direct_r;
  logic [POST_W-1:0] post_r;
  logic [FB_W-1:0]   fb_r;
  logic [15:0]       data_r;
  logic              wr_d_r;
  logic              ptr_rst_r;
  logic              present_r;
  pwr_state_t        state;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:1] == ofs[7:1]);
  endfunction : hit

  logic        sel;
  logic        wr_strobe;
  logic        wr_any;
  logic        rd_sel;
  logic        wr_pwr;
  logic        wr_clk;
  logic        wr_rst;
  logic        wr_frac;
  logic        wr_misc;
  logic        wr_pll;
  logic        soft_reset_all;
  logic        standby_exit;
  logic        hibern_exit;
  logic [15:0] rd_mux;
  logic [15:0] pll_word;

  assign sel       = ~cs_n_i;
  // A write is taken once, on the first cycle the strobe is low.
  assign wr_strobe = sel & ~wr_n_i & ~wr_d_r;
  // In coma only the reset-all bit is reachable.
  assign wr_any    = wr_strobe & ~coma_r;
  assign rd_sel    = sel & ~rd_n_i & ~coma_r;
  assign wr_pwr    = wr_any & hit(addr_i, OFS_PWR_CTRL);
  assign wr_clk    = wr_any & hit(addr_i, OFS_CLK_CTRL);
  assign wr_rst    = wr_strobe & hit(addr_i, OFS_SW_RESET);
  assign wr_frac   = wr_any & hit(addr_i, OFS_CLK_FRAC);
  assign wr_misc   = wr_any & hit(addr_i, OFS_MISC);
  assign wr_pll    = wr_any & hit(addr_i, OFS_PLL_CTRL);

  assign soft_reset_all = wr_rst & data_i[SWRST_ALL_BIT];

  assign standby_exit = wr_clk & ~int_clk_en_r & data_i[CLK_INT_EN_BIT];
  assign hibern_exit  = wr_misc & hibern_r & ~data_i[MISC_HIBERN_BIT];

  // Reserved PLL bits are never stored, so they read as zero.
  assign pll_word = {bypass_r, direct_r, 7'h00, post_r, fb_r} & PLL_RD_MASK;

  always_comb
  begin
    rd_mux = 16'h0000;
    if (hit(addr_i, OFS_PWR_CTRL))
      rd_mux[PWR_BUS_ON_BIT] = bus_on_r;
    else if (hit(addr_i, OFS_CLK_CTRL))
    begin
      rd_mux[CLK_INT_EN_BIT]              = int_clk_en_r;
      rd_mux[CLK_IDLE_BIT]                = idle_r;
      rd_mux[CLK_DIV_LSB +: DIV_W]        = div_r;
    end
    else if (hit(addr_i, OFS_CLK_FRAC))
    begin
      rd_mux[FRAC_N_LSB +: N_W] = frac_n_r;
      rd_mux[FRAC_M_LSB +: M_W] = frac_m_r;
    end
    else if (hit(addr_i, OFS_MISC))
    begin
      rd_mux[MISC_DMA_EN_BIT] = dma_en_r;
      rd_mux[MISC_INT_PP_BIT] = int_pp_r;
      rd_mux[MISC_HIBERN_BIT] = hibern_r;
    end
    else if (hit(addr_i, OFS_PLL_CTRL))
      rd_mux = pll_word;
    else if (hit(addr_i, OFS_REVISION))
      rd_mux[REV_CODE_LSB +: 8] = REV_CODE;
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Entering coma wipes every register back to its reset value, so the
  // host must reinitialise after waking with the reset-all bit.
  logic wipe;
  assign wipe = soft_reset_all | (wr_misc & data_i[MISC_COMA_BIT]);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_on_r     <= 1'b0;
      int_clk_en_r <= 1'b0;
      idle_r       <= 1'b0;
      div_r        <= '0;
    end
    else if (wipe)
    begin
      bus_on_r     <= 1'b0;
      int_clk_en_r <= 1'b0;
      idle_r       <= 1'b0;
      div_r        <= '0;
    end
    else
    begin
      if (wr_pwr)
        bus_on_r <= data_i[PWR_BUS_ON_BIT];
      if (wr_clk)
      begin
        int_clk_en_r <= data_i[CLK_INT_EN_BIT];
        idle_r       <= data_i[CLK_IDLE_BIT];
        div_r        <= data_i[CLK_DIV_LSB +: DIV_W];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frac_n_r <= N_RST;
      frac_m_r <= M_RST;
      bypass_r <= BYPASS_RST;
      direct_r <= DIRECT_RST;
      post_r   <= POST_RST;
      fb_r     <= FB_RST;
    end
    else if (wipe)
    begin
      frac_n_r <= N_RST;
      frac_m_r <= M_RST;
      bypass_r <= BYPASS_RST;
      direct_r <= DIRECT_RST;
      post_r   <= POST_RST;
      fb_r     <= FB_RST;
    end
    else
    begin
      if (wr_frac)
      begin
        frac_n_r <= data_i[FRAC_N_LSB +: N_W];
        frac_m_r <= data_i[FRAC_M_LSB +: M_W];
      end
      if (wr_pll)
      begin
        bypass_r <= data_i[PLL_BYPASS_BIT];
        direct_r <= data_i[PLL_DIRECT_BIT];
        post_r   <= data_i[PLL_POST_LSB +: POST_W];
        fb_r     <= data_i[PLL_FB_LSB +: FB_W];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      coma_r   <= 1'b0;
      dma_en_r <= DMA_EN_RST;
      int_pp_r <= 1'b0;
      hibern_r <= 1'b0;
    end
    else if (soft_reset_all)
    begin
      coma_r   <= 1'b0;
      dma_en_r <= DMA_EN_RST;
      int_pp_r <= 1'b0;
      hibern_r <= 1'b0;
    end
    else if (wr_misc)
    begin
      coma_r   <= data_i[MISC_COMA_BIT];
      dma_en_r <= data_i[MISC_COMA_BIT] ? DMA_EN_RST : data_i[MISC_DMA_EN_BIT];
      int_pp_r <= data_i[MISC_COMA_BIT] ? 1'b0 : data_i[MISC_INT_PP_BIT];
      hibern_r <= data_i[MISC_COMA_BIT] ? 1'b0 : data_i[MISC_HIBERN_BIT];
    end
  end

  // ****************************************
  // Bus answer and event registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_r    <= 16'h0000;
      wr_d_r    <= 1'b0;
      ptr_rst_r <= 1'b0;
      present_r <= 1'b0;
    end
    else
    begin
      data_r    <= rd_sel ? rd_mux : 16'h0000;
      wr_d_r    <= sel & ~wr_n_i;
      ptr_rst_r <= standby_exit | hibern_exit;
      present_r <= card_detect_input_i;
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  always_comb
  begin
    if (coma_r)
      state = PS_COMA;
    else if (hibern_r)
      state = PS_HIBERN;
    else if (!int_clk_en_r)
      state = PS_STANDBY;
    else if (idle_r)
      state = PS_IDLE;
    else
      state = PS_RUN;
  end

  logic clk_live;
  logic detect_live;
  logic card_clk_run;
  logic card_clk;

  always_comb
  begin
    case (state)
      PS_RUN:
      begin
        clk_live    = 1'b1;
        detect_live = 1'b1;
      end
      PS_IDLE, PS_STANDBY:
      begin
        clk_live    = state == PS_IDLE;
        detect_live = 1'b1;
      end
      default:
      begin
        clk_live    = 1'b0;
        detect_live = 1'b0;
      end
    endcase
  end

  // The card clock stops in idle, but the oscillator and PLL keep going.
  assign card_clk_run = (state == PS_RUN);

  card_clk_div u_card_clk_div (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .run_i            (card_clk_run),
    .div_i            (div_r),
    .n_i              (frac_n_r),
    .m_i              (frac_m_r),
    .card_bus_clock_o (card_clk)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign data_o            = data_r;
  assign data_oe_o         = rd_sel;
  assign card_bus_clock_o  = card_clk;
  assign card_supply_en_o  = bus_on_r & ~coma_r;
  assign osc_en_o          = ~hibern_r & ~coma_r;
  // Standby powers the PLL down; the bypass bit does not keep it alive.
  assign pll_power_down_o  = ~clk_live;
  assign pll_bypass_o      = bypass_r;
  // The post divider only shapes duty cycle; frequency is set by fb alone.
  assign pll_direct_o      = direct_r;
  assign pll_fb_div_o      = fb_r;
  assign pll_post_div_o    = post_r;
  assign buffer_power_en_o = ~hibern_r & ~coma_r;
  assign buffer_ptr_reset_o = ptr_rst_r | wipe;
  assign dma_req_en_o      = dma_en_r & ~coma_r;
  assign int_push_pull_o   = int_pp_r;
  assign pins_active_o     = ~coma_r;
  assign card_present_o    = present_r & detect_live;
  assign card_irq_o        = card_irq_i & detect_live;
  assign power_state_o     = state;

endmodule : sdh_power_clock

// ===== sdh_power_clock_asserts.sv
`timescale 1ns/1ps
// ****************
// Port checks
// ****************
module sdh_power_clock_asserts (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      cs_n_i,
  input wire logic                      rd_n_i,
  input wire logic                      wr_n_i,
  input wire logic [7:0]                addr_i,
  input wire logic [15:0]               data_i,
  input wire logic [15:0]               data_o,
  input wire logic                      data_oe_o,
  input wire logic                      card_irq_i,
  input wire logic                      card_present_o,
  input wire logic                      card_irq_o,
  input wire logic                      card_bus_clock_o,
  input wire logic                      card_supply_en_o,
  input wire logic                      osc_en_o,
  input wire logic                      pll_power_down_o,
  input wire logic                      pll_bypass_o,
  input wire logic                      pll_direct_o,
  input wire logic [sdh_pkg::FB_W-1:0]  pll_fb_div_o,
  input wire logic [sdh_pkg::POST_W-1:0] pll_post_div_o,
  input wire logic                      buffer_power_en_o,
  input wire logic                      buffer_ptr_reset_o,
  input wire logic                      pins_active_o,
  input wire logic [2:0]                power_state_o
);
  import sdh_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] wd_r;
  logic [15:0] pll_r;
  wire logic deep_off = power_state_o >= 3'd3;
  wire logic live     = power_state_o != 3'd4;
  // Previous write data and PLL fields, so reads and writes can be judged a cycle later.
  always_ff @(posedge clk_i)
  begin
    wd_r  <= data_i;
    pll_r <= {pll_bypass_o, pll_direct_o, 7'h00, pll_post_div_o, pll_fb_div_o};
  end
  sequence s_pll_wr;
    !cs_n_i && !wr_n_i && $past(wr_n_i) && addr_i[7:1] == OFS_PLL_CTRL[7:1] && live;
  endsequence
  sequence s_wake;
    (power_state_o inside {3'd2, 3'd3}) ##1 (power_state_o < $past(power_state_o));
  endsequence
  property p_pll_wr;
    s_pll_wr |=> pll_fb_div_o == wd_r[4:0] && pll_post_div_o == wd_r[6:5]
      && pll_bypass_o == wd_r[15] && pll_direct_o == wd_r[14];
  endproperty
  property p_pll_rd;
    !cs_n_i && !rd_n_i && addr_i[7:1] == OFS_PLL_CTRL[7:1] && live |=> data_o == pll_r;
  endproperty
  property p_rev_rd;
    !cs_n_i && !rd_n_i && addr_i[7:1] == OFS_REVISION[7:1] && live |=> data_o == {REV_CODE, 8'h00};
  endproperty
  property p_oe;
    data_oe_o == (!cs_n_i && !rd_n_i && live);
  endproperty
  property p_irq;
    card_irq_o == (card_irq_i && !deep_off);
  endproperty
  property p_osc;
    osc_en_o == !deep_off && buffer_power_en_o == !deep_off;
  endproperty
  property p_pll_pd;
    pll_power_down_o == (power_state_o >= 3'd2);
  endproperty
  property p_coma;
    !live |-> !pins_active_o && !card_supply_en_o;
  endproperty
  property p_detect;
    deep_off [*2] |-> !card_present_o;
  endproperty
  property p_clk_stop;
    (power_state_o != 3'd0) [*2] |-> !card_bus_clock_o;
  endproperty
  property p_ptr;
    s_wake |-> ##[0:2] buffer_ptr_reset_o;
  endproperty
  a_pll_wr:   assert property (p_pll_wr) else $error("PLL fields do not follow the write");
  a_pll_rd:   assert property (p_pll_rd) else $error("PLL read value wrong");
  a_rev_rd:   assert property (p_rev_rd) else $error("revision read value wrong");
  a_oe:       assert property (p_oe) else $error("read enable wrong");
  a_irq:      assert property (p_irq) else $error("card interrupt gating wrong");
  a_osc:      assert property (p_osc) else $error("oscillator or buffer supply wrong");
  a_pll_pd:   assert property (p_pll_pd) else $error("PLL power down wrong");
  a_coma:     assert property (p_coma) else $error("pins active in deep power off");
  a_detect:   assert property (p_detect) else $error("card detect seen while off");
  a_clk_stop: assert property (p_clk_stop) else $error("card clock runs while stopped");
  a_ptr:      assert property (p_ptr) else $error("no buffer pointer reset on wake");
endmodule : sdh_power_clock_asserts

bind sdh_power_clock sdh_power_clock_asserts i_chk (.*);

// ===== testbench.sv
`timescale 1ns/1ps
// ****************
// Power and clock bench
// ****************
module testbench;
  import sdh_pkg::*;
  logic clk_i, rst_n_i, card_detect_input_i, card_irq_i;
  logic last_clk = 1'b0;
  wire logic cs_n_i, rd_n_i, wr_n_i, data_oe_o, card_present_o, card_irq_o, card_bus_clock_o;
  wire logic card_supply_en_o, osc_en_o, pll_power_down_o, pll_bypass_o, pll_direct_o;
  wire logic buffer_power_en_o, buffer_ptr_reset_o, dma_req_en_o, int_push_pull_o, pins_active_o;
  wire logic [7:0]        addr_i;
  wire logic [15:0]       data_i, data_o;
  wire logic [FB_W-1:0]   pll_fb_div_o;
  wire logic [POST_W-1:0] pll_post_div_o;
  wire logic [2:0]        power_state_o;
  int num_errors, checks_done, pulses, toggles, n0;
  logic [15:0] v;

  sdh_power_clock i_dut (.*);
  host_bus_model i_host (.clk_i(clk_i), .data_o(data_o), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
                         .wr_n_o(wr_n_i), .addr_o(addr_i), .wdata_o(data_i));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (buffer_ptr_reset_o === 1'b1) pulses++;
    if (card_bus_clock_o !== last_clk) toggles++;
    last_clk = card_bus_clock_o;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic t_defaults;
    i_host.rd(OFS_PLL_CTRL, v);
    check(v, 16'hc024);
    i_host.wr(OFS_REVISION, 16'hffff);
    i_host.rd(OFS_REVISION, v);
    check(v, {REV_CODE, 8'h00});
    i_host.rd(8'h00, v);
    check(v, 16'h0000);
    check({13'h0, power_state_o}, {13'h0, PS_STANDBY});
    check({14'h0, dma_req_en_o, int_push_pull_o}, 16'h0002);
  endtask : t_defaults
  task automatic t_pll;
    i_host.wr(OFS_PLL_CTRL, 16'hffff);
    i_host.rd(OFS_PLL_CTRL, v);
    check(v, 16'hc07f);
    // Feedback 7 with each post setting; the software picks only legal ranges in a real system.
    for (int p = 0; p < 4; p++)
    begin
      i_host.wr(OFS_PLL_CTRL, {9'h07f, p[1:0], 5'h07});
      settle;
      check({pll_bypass_o, pll_direct_o, 7'h0, pll_post_div_o, pll_fb_div_o}, {9'h0, p[1:0], 5'h07});
    end
  endtask : t_pll
  task automatic t_light_modes;
    n0 = pulses;
    i_host.wr(OFS_CLK_FRAC, 16'h0001);
    i_host.wr(OFS_CLK_CTRL, 16'h0101);
    settle;
    check({13'h0, power_state_o}, {13'h0, PS_RUN});
    check(16'(pulses - n0), 16'h0001);
    n0 = toggles;
    repeat (20) @(posedge clk_i);
    #1;
    check(16'(toggles - n0), 16'h0014);
    i_host.wr(OFS_PWR_CTRL, 16'h0100);
    settle;
    check({15'h0, card_supply_en_o}, 16'h0001);
    i_host.wr(OFS_PWR_CTRL, 16'h0000);
    settle;
    check({15'h0, card_supply_en_o}, 16'h0000);
    i_host.wr(OFS_CLK_CTRL, 16'h0105);
    card_irq_i <= 1'b1;
    settle;
    n0 = toggles;
    repeat (10) @(posedge clk_i);
    check(16'(toggles - n0), 16'h0000);
    check({10'h0, power_state_o, osc_en_o, pll_power_down_o, card_irq_o}, {10'h0, PS_IDLE, 3'b101});
    i_host.wr(OFS_CLK_CTRL, 16'h0100);
    settle;
    check({10'h0, power_state_o, osc_en_o, pll_power_down_o, card_irq_o}, {10'h0, PS_STANDBY, 3'b111});
  endtask : t_light_modes
  task automatic t_deep_modes;
    check({15'h0, card_present_o}, 16'h0001);
    i_host.wr(OFS_MISC, 16'h000a);
    settle;
    check({13'h0, power_state_o}, {13'h0, PS_HIBERN});
    check({12'h0, osc_en_o, buffer_power_en_o, card_present_o, card_irq_o}, 16'h0000);
    i_host.rd(OFS_PLL_CTRL, v);
    check(v, 16'h0067);
    n0 = pulses;
    i_host.wr(OFS_MISC, 16'h0006);
    settle;
    check(16'(pulses - n0), 16'h0001);
    check({14'h0, dma_req_en_o, int_push_pull_o}, 16'h0003);
    i_host.wr(OFS_MISC, 16'h0001);
    settle;
    check({13'h0, power_state_o}, {13'h0, PS_COMA});
    check({12'h0, pins_active_o, card_supply_en_o, card_present_o, dma_req_en_o}, 16'h0000);
    check({pll_bypass_o, pll_direct_o, 7'h0, pll_post_div_o, pll_fb_div_o}, 16'hc024);
    i_host.rd(OFS_PLL_CTRL, v);
    check(v, 16'h0000);
    i_host.wr(OFS_SW_RESET, 16'h0100);
    settle;
    i_host.rd(OFS_PLL_CTRL, v);
    check(v, 16'hc024);
    i_host.wr(OFS_MISC, 16'h0001);
    settle;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle;
    check({13'h0, power_state_o}, {13'h0, PS_STANDBY});
  endtask : t_deep_modes

  initial
  begin
    rst_n_i = 1'b0;
    card_detect_input_i = 1'b1;
    card_irq_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_defaults;
    t_pll;
    t_light_modes;
    t_deep_modes;
    give_verdict;
  end
  initial
  begin
    #400000;
    num_errors++;
    give_verdict;
  end
endmodule : testbench
